// ==== hw/por_seq_pkg.sv ====
// Package: constants for the power-on reset sequencer
package por_seq_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int CONFIG_TIME_US = 450;
    localparam int BANK_SETTLE_US = 2;
    localparam int CONFIG_CYCLES = CONFIG_TIME_US * CLK_MHZ;
    localparam int BANK_SETTLE_CYCLES = BANK_SETTLE_US * CLK_MHZ;
    localparam int CLEAR_CYCLES = 4;
    localparam int CNT_W = 20;
    localparam int NUM_BANKS = 4;

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [5:0] {
        ST_OFF      = 6'h01,
        ST_LOAD     = 6'h02,
        ST_BANKWAIT = 6'h04,
        ST_SETTLE   = 6'h08,
        ST_CLEAR    = 6'h10,
        ST_USER     = 6'h20
    } seq_state_t;
endpackage

// ==== hw/power_on_reset_sequencer.sv ====
// Power-on reset sequencer: supply watch, download, clear and I/O release
`timescale 1ns/1ps
module power_on_reset_sequencer
    import por_seq_pkg::*;
#(
    parameter int BANKS = NUM_BANKS,
    parameter int CONFIG_CYC = CONFIG_CYCLES,
    parameter int SETTLE_CYC = BANK_SETTLE_CYCLES,
    parameter bit LOW_POWER = 1'b0
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Supply flags from analog comparators
    input wire logic core_supply_good,
    input wire logic core_supply_sag,
    input wire logic [BANKS-1:0] bank_supply_good,
    // Optional device-wide pins and their enables
    input wire logic clear_pin_enable,
    input wire logic device_wide_clear_pin_n,
    input wire logic oe_pin_enable,
    input wire logic device_wide_output_enable_pin,
    // Configuration flash download
    output logic download_start,
    input wire logic download_done,
    // Outputs to the core
    output logic io_tristate,
    output logic io_weak_pullup,
    output logic config_memory_reset,
    output logic register_clear,
    output logic user_mode
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Load must leave room for the sync delay and the clear cycles
    localparam int LOAD_LAST = CONFIG_CYC - CLEAR_CYCLES - 4;

    if (BANKS < 1) begin : g_bad_banks
        $error("power_on_reset_sequencer: BANKS below one");
    end
    if (CONFIG_CYC >= (1 << CNT_W) || SETTLE_CYC >= (1 << CNT_W)) begin : g_bad_width
        $error("power_on_reset_sequencer: count too wide for the counter");
    end
    if (LOAD_LAST < 1) begin : g_bad_config
        $error("power_on_reset_sequencer: configuration count too short");
    end
    if (SETTLE_CYC < 1) begin : g_bad_settle
        $error("power_on_reset_sequencer: settle count below one");
    end
    if (CLEAR_CYCLES < 2) begin : g_bad_clear
        $error("power_on_reset_sequencer: clear needs two cycles");
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Every flag here is asynchronous to core_clk
    localparam int SW = BANKS + 5;
    logic [SW-1:0] raw, s1_q, s2_q;
    assign raw = {bank_supply_good, core_supply_good, core_supply_sag,
                  device_wide_clear_pin_n, device_wide_output_enable_pin, download_done};
    always_ff @(posedge core_clk) begin
        s1_q <= raw;
        s2_q <= s1_q;
    end
    logic done_s, oe_s, clr_n_s, sag_s, core_s, banks_ok;
    assign done_s = s2_q[0];
    assign oe_s = s2_q[1];
    assign clr_n_s = s2_q[2];
    assign sag_s = s2_q[3];
    assign core_s = s2_q[4];
    assign banks_ok = &s2_q[SW-1:5];

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    seq_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic regs_held_q, regs_held_d;
    logic loaded_q, loaded_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        regs_held_d = regs_held_q;
        loaded_d = loaded_q;
        unique case (state_q)
            ST_OFF: begin
                cnt_d = '0;
                loaded_d = 1'b0;
                regs_held_d = 1'b1;
                if (core_s && !sag_s) begin
                    state_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (cnt_q < CNT_W'(CONFIG_CYC)) begin
                    cnt_d = cnt_q + 1'b1;
                end
                // A slow flash copy holds the load until done
                if (done_s) begin
                    loaded_d = 1'b1;
                end
                if ((done_s || loaded_q) && cnt_q >= CNT_W'(LOAD_LAST)) begin
                    cnt_d = '0;
                    // Late banks add the settle time after the last one
                    state_d = banks_ok ? ST_CLEAR : ST_BANKWAIT;
                end
            end
            ST_BANKWAIT: begin
                if (banks_ok) begin
                    cnt_d = '0;
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                cnt_d = cnt_q + 1'b1;
                // A bank that drops restarts the settle time
                if (!banks_ok) begin
                    cnt_d = '0;
                    state_d = ST_BANKWAIT;
                end else if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin
                    cnt_d = '0;
                    state_d = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                cnt_d = cnt_q + 1'b1;
                // Registers go a cycle ahead of the pins
                if (cnt_q == CNT_W'(CLEAR_CYCLES - 2)) begin
                    regs_held_d = 1'b0;
                end
                if (!banks_ok) begin
                    cnt_d = '0;
                    regs_held_d = 1'b1;
                    state_d = ST_BANKWAIT;
                end else if (cnt_q == CNT_W'(CLEAR_CYCLES - 1)) begin
                    state_d = ST_USER;
                end
            end
            ST_USER: begin
                cnt_d = '0;
                // Bank supplies are not watched once running
                // Low-power variant trusts the core supply from here
                if (!LOW_POWER && sag_s) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        // Brown-out before user mode aborts the load
        if (state_q != ST_USER && state_q != ST_OFF && (sag_s || !core_s)) begin
            state_d = ST_OFF;
        end
        // Registers are held again on the same edge as the reset
        if (state_d == ST_OFF) begin
            regs_held_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_OFF;
            cnt_q <= '0;
            regs_held_q <= 1'b1;
            loaded_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            regs_held_q <= regs_held_d;
            loaded_q <= loaded_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Outputs come from next state so they change with it
    logic tri_d, clr_d, rst_d, start_d, um_d;
    always_comb begin
        um_d = (state_d == ST_USER);
        tri_d = !um_d || (oe_pin_enable && !oe_s);
        clr_d = regs_held_d || (clear_pin_enable && !clr_n_s);
        rst_d = (state_d == ST_OFF);
        start_d = (state_q == ST_OFF) && (state_d == ST_LOAD);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            io_tristate <= 1'b1;
            io_weak_pullup <= 1'b1;
            register_clear <= 1'b1;
            config_memory_reset <= 1'b1;
            download_start <= 1'b0;
            user_mode <= 1'b0;
        end else begin
            io_tristate <= tri_d;
            io_weak_pullup <= tri_d;
            register_clear <= clr_d;
            config_memory_reset <= rst_d;
            download_start <= start_d;
            user_mode <= um_d;
        end
    end
endmodule

// ==== sim/supply_model.sv ====
// Board supply and flash copy model
`timescale 1ns/1ps
module supply_model (
    // Bench controls
    input wire logic core_clk,
    input wire logic core_on,
    input wire logic bank_on,
    input wire logic sag,
    // Sequencer side
    input wire logic download_start,
    output logic core_supply_good,
    output logic core_supply_sag,
    output logic [3:0] bank_supply_good,
    output logic download_done
);
    int n = 0;
    assign core_supply_good = core_on && !sag;
    assign core_supply_sag = sag;
    assign bank_supply_good = {4{bank_on}};
    // Copy lost with the core, so a reload waits again
    always_ff @(posedge core_clk) n <= !core_supply_good ? 0 : download_start ? 1 : n + (n > 0 && n < 10);
    assign download_done = n == 10;
endmodule

// ==== sim/power_on_reset_sequencer_checker.sv ====
// Port assertions for the sequencer
`timescale 1ns/1ps
module power_on_reset_sequencer_checker #(
    parameter int BANKS = 4,
    parameter bit LOW_POWER = 1'b0
) (
    // Clock, reset, inputs
    input wire logic core_clk,
    input wire logic reset,
    input wire logic core_supply_sag,
    input wire logic [BANKS-1:0] bank_supply_good,
    input wire logic clear_pin_enable,
    input wire logic device_wide_clear_pin_n,
    input wire logic oe_pin_enable,
    input wire logic device_wide_output_enable_pin,
    // Outputs
    input wire logic download_start,
    input wire logic io_tristate,
    input wire logic io_weak_pullup,
    input wire logic config_memory_reset,
    input wire logic register_clear,
    input wire logic user_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // Sag must outlast the synchronizer
    sequence sag_in_user; user_mode && core_supply_sag ##1 core_supply_sag [*5]; endsequence
    AST_TRI: assert property (!user_mode |-> io_tristate && io_weak_pullup) else $error("pins free");
    AST_START: assert property (download_start |=> (!download_start && !user_mode) [*8]) else $error("start");
    AST_PULL: assert property (io_weak_pullup == io_tristate) else $error("pull-up");
    AST_BANK: assert property ($rose(user_mode) |-> &$past(bank_supply_good, 4)) else $error("banks");
    AST_USER: assert property ($rose(user_mode) && !oe_pin_enable |-> !io_tristate) else $error("release");
    AST_SAG: assert property (((!LOW_POWER) and sag_in_user) |-> config_memory_reset) else $error("sag");
    AST_HOLD: assert property ((LOW_POWER and sag_in_user) |-> user_mode) else $error("low power");
    AST_CMR: assert property (config_memory_reset |-> io_tristate && !user_mode) else $error("cfg reset");
    AST_REL: assert property ($fell(io_tristate) && !clear_pin_enable |-> !$past(register_clear))
        else $error("order");
    AST_CLR: assert property ((clear_pin_enable && !device_wide_clear_pin_n) [*4] |-> register_clear)
        else $error("clear pin");
    AST_OE: assert property ((oe_pin_enable && !device_wide_output_enable_pin) [*4] |-> io_tristate)
        else $error("oe pin");
endmodule
bind power_on_reset_sequencer power_on_reset_sequencer_checker #(.BANKS(BANKS), .LOW_POWER(LOW_POWER)) chk (
    .core_clk, .reset, .core_supply_sag, .bank_supply_good, .clear_pin_enable, .device_wide_clear_pin_n,
    .oe_pin_enable, .device_wide_output_enable_pin, .download_start, .io_tristate, .io_weak_pullup,
    .config_memory_reset, .register_clear, .user_mode);

// ==== sim/power_on_reset_sequencer_tb.sv ====
// Sequencer testbench
`timescale 1ns/1ps
`define CHK(s, e, v) begin tests_run++; if ((v) !== (e)) begin mismatches++; $display("mismatch %s %0h %0h", s, e, v); end end
module power_on_reset_sequencer_tb;
    logic core_clk = 0, reset = 1, core_on = 0, bank_on = 0, sag = 0, clear_pin_enable = 0, oe_pin_enable = 0;
    logic device_wide_clear_pin_n = 1, device_wide_output_enable_pin = 0, core_supply_good, core_supply_sag;
    logic download_start, download_done, io_tristate, io_weak_pullup, config_memory_reset, register_clear, user_mode;
    logic [3:0] bank_supply_good;
    logic lp_io_tristate, lp_user_mode;
    int mismatches = 0, tests_run = 0, n;
    initial forever #2.5 core_clk = ~core_clk;
    supply_model pwr (.core_clk, .core_on, .bank_on, .sag, .download_start, .core_supply_good, .core_supply_sag,
        .bank_supply_good, .download_done);
    // Short counts keep the run brief
    power_on_reset_sequencer #(.CONFIG_CYC(50), .SETTLE_CYC(8)) dut (.core_clk, .reset, .core_supply_good,
        .core_supply_sag, .bank_supply_good, .clear_pin_enable, .device_wide_clear_pin_n, .oe_pin_enable,
        .device_wide_output_enable_pin, .download_start, .download_done, .io_tristate, .io_weak_pullup,
        .config_memory_reset, .register_clear, .user_mode);
    // Low-power variant sees the same supplies and flash
    power_on_reset_sequencer #(.CONFIG_CYC(50), .SETTLE_CYC(8), .LOW_POWER(1'b1)) dut_lp (.core_clk, .reset,
        .core_supply_good, .core_supply_sag, .bank_supply_good, .clear_pin_enable, .device_wide_clear_pin_n,
        .oe_pin_enable, .device_wide_output_enable_pin, .download_start(), .download_done,
        .io_tristate(lp_io_tristate), .io_weak_pullup(), .config_memory_reset(), .register_clear(),
        .user_mode(lp_user_mode));
    task automatic step(int k); repeat (k) @(posedge core_clk); #1; endtask
    task automatic to_user(); while (user_mode !== 1'b1 && n < 400) begin step(1); n++; end endtask
    // Scaled zero-volt hold before the supplies return
    task automatic power_down(); sag = 1; core_on = 0; step(6); sag = 0; step(14); endtask
    task automatic t_power_up();
        bank_on = 1;
        core_on = 1;
        n = 0;
        while (download_start !== 1'b1 && n < 20) begin step(1); n++; end
        `CHK("start", 1'b1, download_start)
        `CHK("cfg_rst", 1'b0, config_memory_reset)
        `CHK("tri_load", 1'b1, io_tristate && io_weak_pullup && !user_mode)
        step(1);
        n++;
        `CHK("start_pulse", 1'b0, download_start)
        to_user();
        `CHK("cfg_time", 1'b1, n >= 45 && n <= 50)
        `CHK("tri", 1'b0, io_tristate || io_weak_pullup)
        `CHK("clr", 1'b0, register_clear)
        `CHK("lp_user", 1'b1, lp_user_mode)
    endtask
    task automatic t_brownout();
        bank_on = 0;
        step(10);
        `CHK("bank_ign", 1'b1, user_mode)
        bank_on = 1;
        sag = 1;
        step(6);
        `CHK("sag_tri", 1'b1, io_tristate && config_memory_reset && !user_mode)
        `CHK("lp_hold", 1'b1, lp_user_mode && !lp_io_tristate)
        sag = 0;
        n = 0;
        to_user();
        `CHK("reload", 1'b1, n >= 45 && n <= 50)
    endtask
    task automatic t_late_banks();
        power_down();
        bank_on = 0;
        core_on = 1;
        step(80);
        `CHK("no_user", 1'b1, io_tristate && register_clear && !user_mode)
        bank_on = 1;
        n = 0;
        to_user();
        `CHK("settle", 1'b1, n >= 12 && n <= 18)
    endtask
    task automatic t_pins();
        power_down();
        clear_pin_enable = 1;
        device_wide_clear_pin_n = 0;
        oe_pin_enable = 1;
        core_on = 1;
        step(70);
        `CHK("oe_hold", 1'b1, user_mode && io_tristate && register_clear)
        device_wide_output_enable_pin = 1;
        step(4);
        `CHK("oe_rel", 1'b1, !io_tristate && register_clear)
        device_wide_clear_pin_n = 1;
        step(4);
        `CHK("clr_rel", 1'b0, register_clear)
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin #10000; mismatches++; stop_test(); end
    initial begin step(2); reset = 0; t_power_up(); t_brownout(); t_late_banks(); t_pins(); stop_test(); end
endmodule
